/* pkg/dscp_pkg.sv */
// Purpose: Shared constants of the serial command port (device and host ends)
// Assumes: 24-bit frames, 20 MHz system clock
`default_nettype none

package dscp_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CMD_BITS = 8;
    localparam int WORD_BITS = 16;
    localparam int SEL_BITS = 6;
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_CODE = 8'h01;
    localparam logic [7:0] CMD_READ = 8'h02;
    localparam logic [7:0] CMD_CTRL = 8'h55;
    localparam logic [7:0] CMD_SRST = 8'h56;
    localparam logic [7:0] CMD_CONF = 8'h57;
    localparam logic [7:0] CMD_GAIN = 8'h58;
    localparam logic [7:0] CMD_OFFS = 8'h59;
    localparam logic [7:0] CMD_WDOG = 8'h95;
    localparam logic [1:0] SEL_STAT = 2'h0;
    localparam logic [1:0] SEL_CODE = 2'h1;
    localparam logic [1:0] SEL_CTRL = 2'h2;
    localparam logic [5:0] SEL_CONF = 6'h0B;
    localparam logic [5:0] SEL_GAIN = 6'h13;
    localparam logic [5:0] SEL_OFFS = 6'h17;
    localparam int CHAIN_BIT = 3;
    localparam int RESET_BIT = 0;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [23:0] SHIFT_RESET = 24'h000000;
    localparam logic [7:0] READ_LEAD = 8'h00;
    // Timing
    localparam int SYS_PERIOD_NS = 50;
    localparam int HOST_LINK_PERIOD_NS = 1000;
    localparam int HOST_HALF_CYC = HOST_LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
    localparam int HOST_LATCH_CYC = 2 * HOST_HALF_CYC;
    // Host command port
    localparam int BUS_AW = 8;
    localparam int BUS_DW = 32;
    localparam logic [7:0] HOST_CTRL = 8'h00;
    localparam logic [7:0] HOST_RX = 8'h04;
    localparam logic [7:0] HOST_TX_BASE = 8'h10;
    localparam int HCTRL_START_BIT = 0;
    localparam int HCTRL_BUSY_BIT = 1;
    localparam int HCTRL_COUNT_LSB = 4;
    localparam int HCTRL_COUNT_W = 4;
endpackage

`default_nettype wire

/* pkg/dscp_link_if.sv */
// Purpose: Four-wire link between host and device
// Assumes: One host, one device per instance
// Notes: Chains are built by joining several instances in the bench
`timescale 1ns/1ps
`default_nettype none

interface dscp_link_if;
    logic link_clk;
    logic latch_strobe;
    logic serial_in;
    logic serial_out;
    modport dev (input link_clk, input latch_strobe, input serial_in, output serial_out);
    modport host (output link_clk, output latch_strobe, output serial_in, input serial_out);
endinterface

`default_nettype wire

/* design/dscp_sync.sv */
// Purpose: Three-flop input synchroniser with edge pulses
// Assumes: Inputs asynchronous to sys_clk_in
// Notes: Level changes once second and third stages agree
`timescale 1ns/1ps
`default_nettype none

module dscp_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // Pins
    input wire logic [WIDTH-1:0] async_in,
    // Filtered level and edges
    output logic [WIDTH-1:0] level_out,
    output logic [WIDTH-1:0] rise_out,
    output logic [WIDTH-1:0] fall_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } dscp_sync_t;

    dscp_sync_t q;
    dscp_sync_t d;

    always_comb
    begin
        d = q;
        d.s1 = async_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // Hold the level while stages disagree
        d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 | q.s3));
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
            q <= '0;
        else
            q <= d;
    end

    assign level_out = q.lvl;
    assign rise_out = d.lvl & ~q.lvl;
    assign fall_out = ~d.lvl & q.lvl;
endmodule // dscp_sync

`default_nettype wire

/* design/dscp_device.sv */
// Purpose: Device end of the serial command port
// Assumes: Link clock well below sys_clk_in / 6
// Notes: Registers stand on the user side as plain outputs
`timescale 1ns/1ps
`default_nettype none

module dscp_device #(
    parameter int DATA_BITS = 16
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // Link
    dscp_link_if.dev link,
    // Status from the analog side
    input wire logic [dscp_pkg::WORD_BITS-1:0] fault_flags_in,
    // Register contents
    output logic [dscp_pkg::WORD_BITS-1:0] output_code_out,
    output logic [dscp_pkg::WORD_BITS-1:0] control_settings_out,
    output logic [dscp_pkg::WORD_BITS-1:0] configuration_settings_out,
    output logic [dscp_pkg::WORD_BITS-1:0] gain_trim_out,
    output logic [dscp_pkg::WORD_BITS-1:0] offset_trim_out,
    // One-cycle events
    output logic soft_reset_out,
    output logic watchdog_restart_out
);
    import dscp_pkg::*;

    if (DATA_BITS != 12 && DATA_BITS != 16)
    begin : g_bad_bits
        $error("DATA_BITS must be 12 or 16");
    end

    // Decoding below assumes command byte plus data word fill the frame
    if (FRAME_BITS != CMD_BITS + WORD_BITS || SEL_BITS > WORD_BITS)
    begin : g_bad_frame
        $error("frame layout does not add up");
    end

    // Low bits beyond the converter width are dropped
    localparam logic [15:0] DATA_MASK = 16'(16'hFFFF << (WORD_BITS - DATA_BITS));

    typedef struct packed {
        logic [FRAME_BITS-1:0] shift;
        logic sout;
        logic rd_pend;
        logic [WORD_BITS-1:0] code;
        logic [WORD_BITS-1:0] ctrl;
        logic [WORD_BITS-1:0] conf;
        logic [WORD_BITS-1:0] gain;
        logic [WORD_BITS-1:0] offs;
        logic srst;
        logic wdog;
    } dscp_dev_t;

    localparam dscp_dev_t DEV_RESET = '{
        shift: SHIFT_RESET,
        sout: 1'b0,
        rd_pend: 1'b0,
        code: REG_RESET,
        ctrl: REG_RESET,
        conf: REG_RESET,
        gain: REG_RESET,
        offs: REG_RESET,
        srst: 1'b0,
        wdog: 1'b0
    };

    localparam int P_CLK = 2;
    localparam int P_LAT = 1;
    localparam int P_SDI = 0;

    dscp_dev_t q;
    dscp_dev_t d;
    logic [2:0] pin_lvl;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    logic chain_on;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    dscp_sync #(
        .WIDTH(3)
    ) u_sync (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .async_in({link.link_clk, link.latch_strobe, link.serial_in}),
        .level_out(pin_lvl),
        .rise_out(pin_rise),
        .fall_out(pin_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [15:0] trim(input logic [15:0] v);
        return v & DATA_MASK;
    endfunction

    function automatic logic [15:0] read_value(input logic [5:0] sel, input dscp_dev_t s);
        logic [15:0] v;
        v = REG_RESET;
        case (sel[1:0])
            SEL_STAT: v = fault_flags_in;
            SEL_CODE: v = s.code;
            SEL_CTRL: v = s.ctrl;
            default:
            begin
                // Only a full match selects these
                case (sel)
                    SEL_CONF: v = s.conf;
                    SEL_GAIN: v = s.gain;
                    SEL_OFFS: v = s.offs;
                    default: v = REG_RESET;
                endcase
            end
        endcase
        return v;
    endfunction

    assign chain_on = q.ctrl[CHAIN_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        d = q;
        d.srst = 1'b0;
        d.wdog = 1'b0;
        // Shifting ignores the latch level
        if (pin_rise[P_CLK])
            d.shift = {q.shift[FRAME_BITS-2:0], pin_lvl[P_SDI]};
        // Output moves on falls so the far end samples on rises
        if (pin_fall[P_CLK])
        begin
            if (chain_on)
                d.sout = q.shift[FRAME_BITS-1];
            else
                d.sout = q.rd_pend & q.shift[FRAME_BITS-1];
        end
        if (pin_rise[P_LAT])
        begin
            // Every chained device commits on the same strobe
            d.rd_pend = 1'b0;
            // A standalone port goes quiet once the readback frame is committed
            if (!chain_on)
                d.sout = 1'b0;
            case (q.shift[FRAME_BITS-1 -: CMD_BITS])
                CMD_CODE: d.code = trim(q.shift[WORD_BITS-1:0]);
                CMD_CTRL: d.ctrl = q.shift[WORD_BITS-1:0];
                CMD_CONF: d.conf = q.shift[WORD_BITS-1:0];
                CMD_GAIN: d.gain = trim(q.shift[WORD_BITS-1:0]);
                CMD_OFFS: d.offs = trim(q.shift[WORD_BITS-1:0]);
                CMD_READ:
                begin
                    // Readback rides the shift register, so it also passes a chain
                    d.shift = {READ_LEAD, read_value(q.shift[SEL_BITS-1:0], q)};
                    d.rd_pend = 1'b1;
                    d.sout = READ_LEAD[CMD_BITS-1];
                end
                CMD_SRST:
                begin
                    if (q.shift[RESET_BIT])
                    begin
                        d = DEV_RESET;
                        d.srst = 1'b1;
                    end
                end
                CMD_WDOG: d.wdog = 1'b1;
                CMD_NOP: d.wdog = 1'b0;
                default: d.wdog = 1'b0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
            q <= DEV_RESET;
        else
            q <= d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign link.serial_out = q.sout;
    assign output_code_out = q.code;
    assign control_settings_out = q.ctrl;
    assign configuration_settings_out = q.conf;
    assign gain_trim_out = q.gain;
    assign offset_trim_out = q.offs;
    assign soft_reset_out = q.srst;
    assign watchdog_restart_out = q.wdog;
endmodule // dscp_device

`default_nettype wire

/* design/dscp_host.sv */
// Purpose: Host end: sends frames, strobes latch, gathers readback
// Assumes: Devices sample with three-flop synchronisers
// Notes: Link clock divided from sys_clk_in
`timescale 1ns/1ps
`default_nettype none

module dscp_host #(
    parameter int MAX_DEV = 4,
    parameter int HALF_CYC = dscp_pkg::HOST_HALF_CYC,
    parameter int LATCH_CYC = dscp_pkg::HOST_LATCH_CYC
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // Link
    dscp_link_if.host link,
    // Command port
    input wire logic [dscp_pkg::BUS_AW-1:0] addr_in,
    input wire logic [dscp_pkg::BUS_DW-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [dscp_pkg::BUS_DW-1:0] rdata_out,
    output logic busy_out
);
    import dscp_pkg::*;

    // Readback crosses two synchronisers inside one half period
    if (HALF_CYC < 10 || HALF_CYC > 255 || LATCH_CYC < 1 || LATCH_CYC > 255 || MAX_DEV < 1 || MAX_DEV > 10)
    begin : g_bad_param
        $error("dscp_host parameters out of range");
    end

    typedef enum logic [4:0] {
        H_IDLE = 5'h01,
        H_LOW = 5'h02,
        H_HIGH = 5'h04,
        H_GAP = 5'h08,
        H_LATCH = 5'h10
    } dscp_hstate_t;

    typedef struct packed {
        dscp_hstate_t st;
        logic [7:0] cnt;
        logic [3:0] word;
        logic [4:0] bitn;
        logic [HCTRL_COUNT_W-1:0] nwords;
        logic [MAX_DEV-1:0][FRAME_BITS-1:0] tx;
        logic [FRAME_BITS-1:0] rx;
        logic sclk;
        logic latch;
        logic mosi;
        logic busy;
        logic [BUS_DW-1:0] rdata;
    } dscp_host_t;

    dscp_host_t q;
    dscp_host_t d;
    logic miso;
    logic tx_hit;
    logic [7:0] tx_idx;

    dscp_sync #(
        .WIDTH(1)
    ) u_sync (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .async_in(link.serial_out),
        .level_out(miso),
        .rise_out(),
        .fall_out()
    );

    assign tx_idx = 8'(addr_in - HOST_TX_BASE) >> 2;
    assign tx_hit = addr_in >= HOST_TX_BASE && addr_in[1:0] == 2'h0 && tx_idx < 8'(MAX_DEV);

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        d = q;
        d.rdata = '0;
        if (rd_in)
        begin
            if (addr_in == HOST_CTRL)
            begin
                d.rdata[HCTRL_BUSY_BIT] = q.busy;
                d.rdata[HCTRL_COUNT_LSB +: HCTRL_COUNT_W] = q.nwords;
            end
            else if (addr_in == HOST_RX)
                d.rdata[FRAME_BITS-1:0] = q.rx;
            else if (tx_hit)
                d.rdata[FRAME_BITS-1:0] = q.tx[tx_idx];
        end
        // Frame contents are frozen while a transfer runs
        if (wr_in && !q.busy)
        begin
            if (tx_hit)
                d.tx[tx_idx] = wdata_in[FRAME_BITS-1:0];
            if (addr_in == HOST_CTRL)
                d.nwords = wdata_in[HCTRL_COUNT_LSB +: HCTRL_COUNT_W];
        end
        d.cnt = q.cnt - 8'h01;
        case (q.st)
            H_IDLE:
            begin
                d.cnt = 8'(HALF_CYC - 1);
                if (wr_in && addr_in == HOST_CTRL && wdata_in[HCTRL_START_BIT] && !q.busy)
                begin
                    if (d.nwords != '0 && d.nwords <= HCTRL_COUNT_W'(MAX_DEV))
                    begin
                        d.st = H_LOW;
                        d.busy = 1'b1;
                        d.word = 4'h0;
                        d.bitn = 5'(FRAME_BITS - 1);
                        d.mosi = d.tx[0][FRAME_BITS-1];
                    end
                end
            end
            H_LOW:
            begin
                if (q.cnt == 8'h00)
                begin
                    d.sclk = 1'b1;
                    d.st = H_HIGH;
                    d.cnt = 8'(HALF_CYC - 1);
                end
            end
            H_HIGH:
            begin
                if (q.cnt == 8'h00)
                begin
                    d.rx = {q.rx[FRAME_BITS-2:0], miso};
                    d.sclk = 1'b0;
                    d.cnt = 8'(HALF_CYC - 1);
                    // Exactly N x 24 clocks, then stop the clock
                    if (q.bitn == 5'h00 && q.word == q.nwords - 4'h1)
                        d.st = H_GAP;
                    else
                    begin
                        d.st = H_LOW;
                        if (q.bitn == 5'h00)
                        begin
                            d.word = q.word + 4'h1;
                            d.bitn = 5'(FRAME_BITS - 1);
                        end
                        else
                            d.bitn = q.bitn - 5'h01;
                        d.mosi = q.tx[d.word][d.bitn];
                    end
                end
            end
            H_GAP:
            begin
                if (q.cnt == 8'h00)
                begin
                    d.latch = 1'b1;
                    d.st = H_LATCH;
                    d.cnt = 8'(LATCH_CYC - 1);
                end
            end
            H_LATCH:
            begin
                if (q.cnt == 8'h00)
                begin
                    d.latch = 1'b0;
                    d.mosi = 1'b0;
                    d.busy = 1'b0;
                    d.st = H_IDLE;
                end
            end
            default: d.st = H_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            q <= '0;
            q.st <= H_IDLE;
        end
        else
            q <= d;
    end

    assign link.link_clk = q.sclk;
    assign link.latch_strobe = q.latch;
    assign link.serial_in = q.mosi;
    assign rdata_out = q.rdata;
    assign busy_out = q.busy;
endmodule // dscp_host

`default_nettype wire

/* tb/dscp_checker.sv */
// Purpose: Wire-level checks on the host side of the serial link
// Assumes: Host built with HALF_CYC 10 and LATCH_CYC 20
// Notes: Instantiated beside the host interface, no bind
`timescale 1ns/1ps
`default_nettype none

module dscp_checker (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // Link
    input wire logic link_clk,
    input wire logic latch_strobe,
    input wire logic serial_in,
    input wire logic serial_out
);
    logic clk_q_ff;
    logic [7:0] rise_cnt_ff;
    logic [7:0] low_cnt_ff;

    // Rises since the last latch, and cycles spent low since the last fall
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            clk_q_ff <= 1'b0;
            rise_cnt_ff <= 8'h00;
            low_cnt_ff <= 8'h00;
        end
        else
        begin
            clk_q_ff <= link_clk;
            if (latch_strobe)
                rise_cnt_ff <= 8'h00;
            else if (link_clk && !clk_q_ff)
                rise_cnt_ff <= rise_cnt_ff + 8'h01;
            if (link_clk)
                low_cnt_ff <= 8'h00;
            else if (low_cnt_ff != 8'hFF)
                low_cnt_ff <= low_cnt_ff + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (reset_in);

    a_reset_idle: assert property ($fell(reset_in) |-> !link_clk && !latch_strobe && !serial_in && !serial_out)
        else $error("link not idle after reset");
    a_whole_frames: assert property ($rose(latch_strobe) |-> rise_cnt_ff == 8'h18 || rise_cnt_ff == 8'h30)
        else $error("latch after a count that is not whole frames");
    a_latch_after_fall: assert property ($rose(latch_strobe) |-> !link_clk && low_cnt_ff >= 8'h08)
        else $error("latch rose too close to a clock edge");
    a_latch_width: assert property ($rose(latch_strobe) |-> latch_strobe[*8] ##12 latch_strobe ##1 !latch_strobe)
        else $error("latch high time wrong");
    a_clock_high: assert property ($rose(link_clk) |-> link_clk[*8] ##2 link_clk ##1 !link_clk)
        else $error("link clock high time wrong");
    a_clock_low: assert property ($fell(link_clk) |-> !link_clk[*8])
        else $error("link clock low time too short");
    a_data_setup: assert property (link_clk && $past(link_clk) |-> $stable(serial_in))
        else $error("serial input moved while clock high");
    a_readback_fall: assert property ($changed(serial_out) |-> !link_clk)
        else $error("serial output moved while clock high");
    a_quiet_latch: assert property (latch_strobe |-> !link_clk)
        else $error("link clock ran during latch");

    c_single: cover property ($rose(latch_strobe) && rise_cnt_ff == 8'h18);
    c_chain: cover property ($rose(latch_strobe) && rise_cnt_ff == 8'h30);
    c_readback: cover property ($changed(serial_out));
endmodule // dscp_checker

`default_nettype wire

/* tb/dscp_tb.sv */
// Purpose: Host and two devices joined over the link, driven from the command port
// Assumes: Host defaults, 16-bit near device, 12-bit far device
// Notes: chained selects standalone fan-out or a two-device chain
`timescale 1ns/1ps
`default_nettype none

module dscp_tb;
    import dscp_pkg::*;
    logic sys_clk_in, reset_in, wr_in, rd_in, busy_out, chained;
    logic [7:0] addr_in;
    logic [31:0] wdata_in, rdata_out, v;
    logic [15:0] fault_word;
    logic [15:0] regs_o [2][5];
    logic srst_o [2];
    logic wdog_o [2];
    logic [15:0] ex [5];
    int n_errors = 0, comparisons = 0, n_wdog = 0, n_srst = 0;
    logic [7:0] cmds [5] = '{CMD_CODE, CMD_CTRL, CMD_CONF, CMD_GAIN, CMD_OFFS};
    logic [5:0] sels [7] = '{6'h3C, 6'h3D, 6'h3E, 6'h0B, 6'h13, 6'h17, 6'h1F};

    dscp_link_if if_h();
    dscp_link_if if_d[2]();
    // Farthest device answers the host only when chained
    assign if_h.serial_out = chained ? if_d[1].serial_out : if_d[0].serial_out;
    assign if_d[0].serial_in = if_h.serial_in;
    assign if_d[1].serial_in = chained ? if_d[0].serial_out : if_h.serial_in;

    dscp_host #(.MAX_DEV(4), .HALF_CYC(10), .LATCH_CYC(20)) i_dscp_host (.sys_clk_in(sys_clk_in),
        .reset_in(reset_in), .link(if_h), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .busy_out(busy_out));
    for (genvar g = 0; g < 2; g++)
    begin : g_dev
        assign if_d[g].link_clk = if_h.link_clk;
        assign if_d[g].latch_strobe = if_h.latch_strobe;
        dscp_device #(.DATA_BITS(g == 1 ? 12 : 16)) i_dscp_device (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
            .link(if_d[g]), .fault_flags_in(fault_word), .output_code_out(regs_o[g][0]),
            .control_settings_out(regs_o[g][1]), .configuration_settings_out(regs_o[g][2]),
            .gain_trim_out(regs_o[g][3]), .offset_trim_out(regs_o[g][4]),
            .soft_reset_out(srst_o[g]), .watchdog_restart_out(wdog_o[g]));
    end
    dscp_checker i_dscp_checker (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .link_clk(if_h.link_clk),
        .latch_strobe(if_h.latch_strobe), .serial_in(if_h.serial_in), .serial_out(if_h.serial_out));

    initial
    begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in)
    begin
        if (wdog_o[0] === 1'b1 && wdog_o[1] === 1'b1) n_wdog++;
        if (srst_o[0] === 1'b1 && srst_o[1] === 1'b1) n_srst++;
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, e, s);
        end
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    // Loads one or two frames, starts them and waits for the latch to finish
    task automatic send(input int n, input logic [23:0] w0, input logic [23:0] w1);
        int i;
        bus_wr(HOST_TX_BASE, {8'h00, w0});
        if (n > 1) bus_wr(HOST_TX_BASE + 8'h04, {8'h00, w1});
        bus_wr(HOST_CTRL, (32'(n) << HCTRL_COUNT_LSB) | 32'h1);
        for (i = 0; i < 3000; i++)
        begin
            @(posedge sys_clk_in);
            #1;
            if (busy_out === 1'b0) break;
        end
        if (i == 3000) chk("busy", 32'h0, 32'(busy_out));
    endtask
    // The far device is 12-bit: code and both trims keep their low nibble at zero
    task automatic chk_regs(input int d);
        logic [15:0] e;
        for (int r = 0; r < 5; r++)
        begin
            e = (d == 1 && r != 1 && r != 2) ? ex[r] & 16'hFFF0 : ex[r];
            chk("reg", {16'h0000, e}, {16'h0000, regs_o[d][r]});
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (30000) @(posedge sys_clk_in);
        n_errors++;
        $display("[ERR] run expected done seen hang");
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////
    initial
    begin
        reset_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 8'h00;
        wdata_in = 32'h0;
        chained = 1'b0;
        fault_word = 16'hA5C3;
        ex = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
        repeat (16) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        chk_regs(0);
        bus_rd(HOST_CTRL, v);
        chk("host ctrl", 32'h0, v);
        bus_rd(8'hF0, v);
        chk("unmapped", 32'h0, v);
        // Every write command, both devices see the same frame
        ex = '{16'hBEEF, 16'h1234, 16'h0F0F, 16'hC3A5, 16'h7E81};
        for (int i = 0; i < 5; i++) send(1, {cmds[i], ex[i]}, 24'h0);
        chk_regs(0);
        chk_regs(1);
        send(1, {CMD_NOP, 16'hFFFF}, 24'h0);
        send(1, {8'h33, 16'hFFFF}, 24'h0);
        send(1, {CMD_WDOG, 16'hFFFF}, 24'h0);
        chk_regs(0);
        chk("watchdog", 32'h1, 32'(n_wdog));
        // Readback of every selector, junk in the ignored data bits
        for (int i = 0; i < 7; i++)
        begin
            send(1, {CMD_READ, 10'h3FF, sels[i]}, 24'h0);
            send(1, {CMD_NOP, 16'h0000}, 24'h0);
            bus_rd(HOST_RX, v);
            chk("readback", {8'h00, READ_LEAD, i == 0 ? fault_word : i == 6 ? 16'h0000 : ex[i - 1]}, v);
        end
        chk_regs(0);
        send(1, {CMD_SRST, 16'h0000}, 24'h0);
        chk("no soft reset", 32'h0, 32'(n_srst));
        send(1, {CMD_SRST, 16'h0001}, 24'h0);
        chk("soft reset", 32'h1, 32'(n_srst));
        ex = '{16'h0000, 16'h0008, 16'h0000, 16'h0000, 16'h0000};
        send(1, {CMD_CTRL, 16'h0008}, 24'h0);
        chk_regs(1);
        @(posedge sys_clk_in);
        chained <= 1'b1;
        // First word lands in the farthest device
        send(2, {CMD_CODE, 16'h1111}, {CMD_CODE, 16'h2222});
        chk("far code", 32'h1110, {16'h0000, regs_o[1][0]});
        chk("near code", 32'h2222, {16'h0000, regs_o[0][0]});
        send(2, {CMD_READ, 16'h0001}, {CMD_READ, 16'h0002});
        send(2, {CMD_NOP, 16'h0000}, {CMD_NOP, 16'h0000});
        bus_rd(HOST_RX, v);
        chk("chain readback", {8'h00, READ_LEAD, 16'h0008}, v);
        wrap_up();
    end
endmodule // dscp_tb

`default_nettype wire
